// ### bench/serial_remote.sv
// serial_remote.sv: remote serial party; sends on rx_pin, decodes tx_pin, drives cts
// assumes 32 sys_clk cycles per bit, 8 data bits, one stop bit
`timescale 1ns/1ps
module serial_remote (
  // clock
  input  wire logic sys_clk,
  // serial lines
  input  wire logic tx_pin,
  output logic      rx_pin,
  output logic      cts_n_pin
);
  localparam int BIT = 32;
  logic [7:0] got_q[$];
  logic [7:0] sh;
  logic [9:0] frame;
  initial begin
    rx_pin = 1'b1;
    cts_n_pin = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_pin = frame[i];
      repeat (BIT) @(negedge sys_clk);
    end
  endtask
  // high before the stop midpoint halts after the current character
  task automatic set_cts(input logic v);
    cts_n_pin = v;
  endtask
  always begin
    @(negedge tx_pin);
    repeat (BIT / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge sys_clk);
      sh[i] = tx_pin;
    end
    got_q.push_back(sh);
    repeat (BIT) @(posedge sys_clk);
  end
endmodule

// ### bench/uart_event_latency_tb.sv
// uart_event_latency_tb.sv: directed checks of transmit, flow control and receive timing
// assumes divisor 2 and a receive tick every second cycle
`timescale 1ns/1ps
module uart_event_latency_tb;
  logic        sys_clk, rst, auto_rts_en, auto_cts_en, rx_clk_tick, thr_write;
  logic        receive_read_strobe, lsr_read, iir_read, thr_ready, rx_pin, cts_n_pin;
  logic        tx_pin, rts_n_pin, irq, holding_empty_flag, transmitter_ready_out, receiver_ready_out;
  logic [15:0] divisor;
  logic [4:0]  rx_threshold;
  logic [7:0]  thr_data, receive_buffer;
  logic [3:0]  interrupt_ident_reg;
  int          miscompares, comparisons, cyc;
  uart_event_latency uart_event_latency_inst (.sys_clk(sys_clk), .rst(rst), .divisor(divisor),
    .auto_rts_en(auto_rts_en), .auto_cts_en(auto_cts_en), .rx_threshold(rx_threshold),
    .rx_clk_tick(rx_clk_tick), .thr_write(thr_write), .thr_data(thr_data), .thr_ready(thr_ready),
    .receive_read_strobe(receive_read_strobe), .lsr_read(lsr_read), .iir_read(iir_read),
    .receive_buffer(receive_buffer), .interrupt_ident_reg(interrupt_ident_reg), .rx_pin(rx_pin),
    .cts_n_pin(cts_n_pin), .tx_pin(tx_pin), .rts_n_pin(rts_n_pin), .irq(irq),
    .holding_empty_flag(holding_empty_flag), .transmitter_ready_out(transmitter_ready_out),
    .receiver_ready_out(receiver_ready_out));
  serial_remote serial_remote_inst (.sys_clk(sys_clk), .tx_pin(tx_pin), .rx_pin(rx_pin), .cts_n_pin(cts_n_pin));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) rx_clk_tick <= ~rx_clk_tick;
  always @(posedge sys_clk) begin
    cyc++;
    // whole run needs about 4000 cycles
    if (cyc == 30000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic pause(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] d);
    thr_write = 1'b1;
    thr_data = d;
    pause(1);
    thr_write = 1'b0;
  endtask
  task automatic pop(input logic [7:0] d);
    chk("byte on line", serial_remote_inst.got_q.pop_front(), d);
  endtask
  task automatic rbr_read();
    receive_read_strobe = 1'b1;
    pause(1);
    receive_read_strobe = 1'b0;
  endtask
  task automatic t_reset();
    chk("reset tx", tx_pin, 1);
    chk("reset rts", rts_n_pin, 1);
    chk("reset flag", holding_empty_flag, 0);
    chk("reset irq", irq, 0);
  endtask
  task automatic t_tx_single();
    int n;
    pause(600);
    wr(8'hA5);
    chk("transmitter_ready_out off", transmitter_ready_out, 1);
    n = 1;
    while (tx_pin === 1'b1 && n < 60) begin
      pause(1);
      n++;
    end
    chk("start delay", n >= 15 && n <= 49, 1);
    while (holding_empty_flag !== 1'b1 && n < 80) begin
      pause(1);
      n++;
    end
    chk("empty delay", n >= 31 && n <= 69, 1);
    chk("ident empty", interrupt_ident_reg, 4'h2);
    chk("irq set", irq, 1);
    chk("transmitter_ready_out back", transmitter_ready_out, 0);
    iir_read = 1'b1;
    pause(1);
    iir_read = 1'b0;
    chk("ident read clears", holding_empty_flag, 0);
    pause(300);
    pop(8'hA5);
  endtask
  // fills the queue until a write is refused, far side stalls with cts while three bytes wait, then drains it
  task automatic t_tx_fill();
    int n;
    wr(8'h11);
    pause(400);
    thr_write = 1'b1;
    for (int i = 0; i < 5; i++) begin
      thr_data = 8'h30 + i[7:0];
      if (i == 4)
        chk("full refuses", thr_ready, 0);
      pause(1);
      if (i == 0)
        chk("write clears empty", holding_empty_flag, 0);
    end
    thr_write = 1'b0;
    pause(100);
    serial_remote_inst.set_cts(1'b1);
    pause(700);
    chk("halted count", serial_remote_inst.got_q.size(), 2);
    pop(8'h11);
    pop(8'h30);
    serial_remote_inst.set_cts(1'b0);
    n = 0;
    while (tx_pin === 1'b1 && n < 80) begin
      pause(1);
      n++;
    end
    chk("resume delay", n <= 52, 1);
    pause(1100);
    for (int i = 1; i < 4; i++)
      pop(8'h30 + i[7:0]);
    chk("drained", serial_remote_inst.got_q.size(), 0);
  endtask
  task automatic t_rx_flow();
    chk("rts asserted", rts_n_pin, 0);
    serial_remote_inst.send(8'h5A);
    chk("receiver_ready_out", receiver_ready_out, 0);
    chk("rx irq", irq, 1);
    chk("rx ident", interrupt_ident_reg, 4'h4);
    serial_remote_inst.send(8'hC3);
    pause(4);
    chk("rts at threshold", rts_n_pin, 1);
    lsr_read = 1'b1;
    pause(1);
    lsr_read = 1'b0;
    chk("status read", interrupt_ident_reg == 4'h4, 0);
    pause(2);
    rbr_read();
    chk("first byte", receive_buffer, 8'h5A);
    pause(2);
    rbr_read();
    chk("second byte", receive_buffer, 8'hC3);
    pause(5);
    chk("rts after last read", rts_n_pin, 0);
    chk("receiver_ready_out idle", receiver_ready_out, 1);
  endtask
  initial begin
    rst = 1'b1;
    divisor = 16'h0002;
    auto_rts_en = 1'b1;
    auto_cts_en = 1'b1;
    rx_threshold = 5'h02;
    rx_clk_tick = 1'b0;
    thr_write = 1'b0;
    thr_data = 8'h00;
    receive_read_strobe = 1'b0;
    lsr_read = 1'b0;
    iir_read = 1'b0;
    pause(8);
    t_reset();
    rst = 1'b0;
    t_tx_single();
    t_tx_fill();
    t_rx_flow();
    conclude();
  end
endmodule

// ### bench/uart_lat_properties.sv
// uart_lat_properties.sv: port timing checks for the serial latency block
// assumes divisor 2, so one baud tick spans two sys_clk cycles
`timescale 1ns/1ps
module uart_lat_properties (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // host side
  input wire logic       thr_write,
  input wire logic       thr_ready,
  input wire logic       iir_read,
  input wire logic       lsr_read,
  input wire logic [3:0] interrupt_ident_reg,
  // status
  input wire logic       tx_pin,
  input wire logic       irq,
  input wire logic       holding_empty_flag,
  input wire logic       transmitter_ready_out
);
  logic       tx_prev_ff;
  logic [8:0] fcnt_ff;
  logic [8:0] idle_ff;
  logic [2:0] queue_ff;
  wire        accept = thr_write && thr_ready;
  wire        tstart = tx_prev_ff && !tx_pin && (fcnt_ff == 9'h000);
  // idle means longer than one whole character with the line high
  wire        idle   = (idle_ff == 9'h1FF);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_prev_ff <= 1'b1;
      fcnt_ff <= 9'h000;
      idle_ff <= 9'h000;
      queue_ff <= 3'h0;
    end else begin
      tx_prev_ff <= tx_pin;
      fcnt_ff <= tstart ? 9'h001 : (fcnt_ff == 9'h13F || fcnt_ff == 9'h000) ? 9'h000 : fcnt_ff + 9'h001;
      idle_ff <= (!tx_pin || accept) ? 9'h000 : (idle ? idle_ff : idle_ff + 9'h001);
      queue_ff <= queue_ff + {2'b00, accept} - {2'b00, tstart};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_start_window: assert property (accept && idle |-> tx_pin [*8] ##[6:42] !tx_pin)
    else $error("start bit outside window");
  a_empty_window: assert property (accept && idle |=> !holding_empty_flag [*8] ##[22:60] holding_empty_flag)
    else $error("holding empty outside window");
  a_start_irq: assert property (tstart && queue_ff == 3'h1 |-> ##[15:21] (irq && holding_empty_flag))
    else $error("interrupt late after start");
  a_transmitter_ready_out_back: assert property (tstart && queue_ff == 3'h1 |-> ##[1:19] !transmitter_ready_out)
    else $error("transmitter ready late");
  a_write_clears: assert property (accept && holding_empty_flag |=> !holding_empty_flag)
    else $error("write left holding empty set");
  a_write_transmitter_ready_out: assert property (accept |=> transmitter_ready_out)
    else $error("transmitter ready stayed active");
  a_ident_clears: assert property (iir_read && interrupt_ident_reg == 4'h2 && !accept |=> !holding_empty_flag)
    else $error("ident read left holding empty");
  a_status_clears: assert property (lsr_read && interrupt_ident_reg == 4'h4 |=> interrupt_ident_reg != 4'h4)
    else $error("status read left receive interrupt");
  c_start: cover property (tstart && queue_ff == 3'h1);
  c_full: cover property (thr_write && !thr_ready);
  c_ident: cover property (iir_read && interrupt_ident_reg == 4'h2);
endmodule
bind uart_event_latency uart_lat_properties uart_lat_properties_inst (
  .sys_clk(sys_clk), .rst(rst), .thr_write(thr_write), .thr_ready(thr_ready),
  .iir_read(iir_read), .lsr_read(lsr_read), .interrupt_ident_reg(interrupt_ident_reg),
  .tx_pin(tx_pin), .irq(irq), .holding_empty_flag(holding_empty_flag),
  .transmitter_ready_out(transmitter_ready_out)
);

// ### common/uart_lat_regs.vh
// uart_lat_regs.vh: timing counts and reset values for the serial latency block
// assumes the includer runs on sys_clk at 40 MHz; baud ticks come from the divisor
// Notes on behaviour
// - interrupt and receiver-ready low within one receive clock after stop bit.
// - auto flow mode: request-to-send deasserts within 2 baud ticks at threshold.
// - auto flow mode: request-to-send reasserts within 2 ticks after last byte read.
// - first data bit of 16th character raises request-to-send within 2 ticks.
// - receive read strobe low with space freed updates request-to-send within 2 ticks.
// - first write to idle transmitter starts start bit 8 to 24 ticks later.
// - interrupt asserts 8 to 10 ticks after transmit start bit begins.
// - holding-empty interrupt rises 16 to 34 ticks after initial write.
// - transmit write clears pending holding-empty interrupt, releasing interrupt output.
// - transmit write makes transmitter-ready inactive.
// - transmitter-ready active again at most 9 ticks after start bit begins.
// - auto clear-to-send: halt only if deasserted before stop bit midpoint.
// - clear-to-send low again resumes start bit within 24 ticks.
// - read of receive buffer or line status clears receive interrupt.
// - baud tick period is reference period times 16-bit divisor.
// - holding-empty cleared by ident read while source, transmit write, reset.
`ifndef UART_LAT_REGS_VH
`define UART_LAT_REGS_VH
`define START_DELAY_TICKS   5'd8
`define HOLDING_EMPTY_FLAG_AFTER_START    5'd9
`define TRANSMITTER_READY_OUT_AFTER_START   5'd9
`define TICKS_PER_BIT       5'd16
`define STOP_MID_TICK       5'd8
`define DATA_BITS           4'd8
`define RX_FULL_LEVEL       5'd16
`define RX_THRESH_RESET     5'd14
`define DIVISOR_RESET       16'h0001
`endif

// ### logic/baud_gen.v
// baud_gen.v: divides sys_clk by a 16-bit divisor into one-cycle baud ticks
// assumes divisor is stable from sys_clk logic; zero acts as one
`timescale 1ns/1ps
`include "uart_lat_regs.vh"
module baud_gen (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // divisor and tick
  input  wire [15:0] divisor,
  output wire        baud_tick
);
  reg  [15:0] cnt_ff;
  wire [15:0] nxt_cnt;
  assign baud_tick = (cnt_ff <= 16'h0001);
  assign nxt_cnt   = baud_tick ? divisor : cnt_ff - 16'h0001;
  always @(posedge sys_clk) begin
    if (rst)
      cnt_ff <= `DIVISOR_RESET;
    else
      cnt_ff <= nxt_cnt;
  end
endmodule

// ### logic/sync_fifo.v
// sync_fifo.v: small synchronous FIFO with valid/ready on both sides
// assumes one clock; depth is a power of two
`timescale 1ns/1ps
module sync_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             rst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  // fill level
  output wire [AW:0]      level
);
  // depth sized to the level counter, so the full compare keeps its width
  localparam [AW:0] DEPTH_W = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ff;
  reg [AW:0]      rd_ff;
  wire            push;
  wire            pop;
  assign level     = wr_ff - rd_ff;
  assign in_ready  = (level != DEPTH_W);
  assign out_valid = (level != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ff[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always @(posedge sys_clk) begin
    if (push)
      mem[wr_ff[AW-1:0]] <= in_data;
  end
  always @(posedge sys_clk) begin
    if (rst) begin
      wr_ff <= {(AW+1){1'b0}};
      rd_ff <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ff <= wr_ff + 1'b1;
      if (pop)
        rd_ff <= rd_ff + 1'b1;
    end
  end
endmodule

// ### logic/uart_event_latency.v
// uart_event_latency.v: one serial channel's event timing, flow control and ready pins
// assumes host strobes are one-cycle pulses on sys_clk; serial pins are asynchronous
`timescale 1ns/1ps
`include "uart_lat_regs.vh"
module uart_event_latency #(
  parameter RX_DEPTH = 16
) (
  // clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // configuration
  input  wire [15:0] divisor,
  input  wire        auto_rts_en,
  input  wire        auto_cts_en,
  input  wire [4:0]  rx_threshold,
  input  wire        rx_clk_tick,
  // host strobes
  input  wire        thr_write,
  input  wire [7:0]  thr_data,
  output wire        thr_ready,
  input  wire        receive_read_strobe,
  input  wire        lsr_read,
  input  wire        iir_read,
  output reg  [7:0]  receive_buffer,
  output wire [3:0]  interrupt_ident_reg,
  // serial pins
  input  wire        rx_pin,
  input  wire        cts_n_pin,
  output wire        tx_pin,
  output wire        rts_n_pin,
  // status outputs
  output wire        irq,
  output wire        holding_empty_flag,
  output wire        transmitter_ready_out,
  output wire        receiver_ready_out
);
  localparam TX_IDLE  = 4'b0001;
  localparam TX_WAIT  = 4'b0010;
  localparam TX_SHIFT = 4'b0100;
  localparam TX_HALT  = 4'b1000;
  // receive depth at the width of the fill count
  localparam [4:0] RX_DEPTH_W = RX_DEPTH;

  wire        baud_tick;
  wire        fifo_out_valid;
  wire [7:0]  fifo_out_data;
  wire [2:0]  fifo_level;
  wire        fifo_pop;

  reg         rx_s1_ff;
  reg         rx_ff;
  reg         cts_s1_ff;
  reg         cts_n_ff;

  reg  [3:0]  tx_state_ff;
  reg  [4:0]  tx_tick_ff;
  reg  [3:0]  tx_bit_ff;
  reg  [9:0]  tx_shift_ff;
  reg         tx_out_ff;
  reg         holding_empty_flag_ff;
  reg  [5:0]  holding_empty_flag_cnt_ff;
  reg         transmitter_ready_out_ff;
  reg         cts_late_ff;

  reg         rx_busy_ff;
  reg  [4:0]  rx_tick_ff;
  reg  [3:0]  rx_bit_ff;
  reg  [7:0]  rx_shift_ff;
  reg  [7:0]  rx_mem [0:RX_DEPTH-1];
  reg  [4:0]  rx_wr_ff;
  reg  [4:0]  rx_rd_ff;
  reg         rda_ff;
  reg         receiver_ready_out_n_ff;
  reg         rts_n_ff;
  reg         rts_pend_ff;
  reg  [1:0]  rts_cnt_ff;

  wire [4:0]  rx_count;
  wire        rx_push;
  wire        rx_pop;
  wire        holding_empty_flag_src;
  wire        nxt_rts_n;

  baud_gen u_baud (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .divisor   (divisor),
    .baud_tick (baud_tick)
  );

  // host data waits here, four deep, so back-to-back writes stall on thr_ready only once it is full
  sync_fifo #(.WIDTH(8), .DEPTH(4), .AW(2)) u_txq (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (thr_write),
    .in_ready  (thr_ready),
    .in_data   (thr_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  always @(posedge sys_clk) begin
    if (rst) begin
      rx_s1_ff  <= 1'b1;
      rx_ff     <= 1'b1;
      cts_s1_ff <= 1'b1;
      cts_n_ff  <= 1'b1;
    end else begin
      rx_s1_ff  <= rx_pin;
      rx_ff     <= rx_s1_ff;
      cts_s1_ff <= cts_n_pin;
      cts_n_ff  <= cts_s1_ff;
    end
  end

  // transmitter: counters run on baud ticks only, so latencies scale with divisor
  assign fifo_pop = (tx_state_ff == TX_WAIT) && baud_tick && (tx_tick_ff == 5'd1);
  assign holding_empty_flag_src = holding_empty_flag_ff;

  always @(posedge sys_clk) begin
    if (rst) begin
      tx_state_ff <= TX_IDLE;
      tx_tick_ff  <= 5'd0;
      tx_bit_ff   <= 4'd0;
      tx_shift_ff <= 10'h3FF;
      tx_out_ff   <= 1'b1;
      cts_late_ff <= 1'b0;
    end else begin
      case (tx_state_ff)
        TX_IDLE: begin
          if (fifo_out_valid && !(auto_cts_en && cts_n_ff)) begin
            tx_state_ff <= TX_WAIT;
            tx_tick_ff  <= `START_DELAY_TICKS;
          end
        end
        TX_WAIT: begin
          if (baud_tick) begin
            if (tx_tick_ff == 5'd1) begin
              tx_state_ff <= TX_SHIFT;
              tx_shift_ff <= {1'b1, fifo_out_data, 1'b0};
              tx_out_ff   <= 1'b0;
              tx_tick_ff  <= `TICKS_PER_BIT;
              tx_bit_ff   <= 4'd0;
              cts_late_ff <= 1'b0;
            end else begin
              tx_tick_ff <= tx_tick_ff - 5'd1;
            end
          end
        end
        TX_SHIFT: begin
          if (baud_tick) begin
            // cts sampled up to stop-bit midpoint only
            if (tx_bit_ff == 4'd9 && tx_tick_ff > `STOP_MID_TICK && cts_n_ff)
              cts_late_ff <= 1'b1;
            if (tx_tick_ff == 5'd1) begin
              if (tx_bit_ff == 4'd9) begin
                tx_out_ff <= 1'b1;
                tx_state_ff <= (auto_cts_en && cts_late_ff) ? TX_HALT : TX_IDLE;
              end else begin
                tx_bit_ff   <= tx_bit_ff + 4'd1;
                tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
                tx_out_ff   <= tx_shift_ff[1];
                tx_tick_ff  <= `TICKS_PER_BIT;
              end
            end else begin
              tx_tick_ff <= tx_tick_ff - 5'd1;
            end
          end
        end
        TX_HALT: begin
          if (!cts_n_ff)
            tx_state_ff <= TX_IDLE;
        end
        default: tx_state_ff <= TX_IDLE;
      endcase
    end
  end
  assign tx_pin = tx_out_ff;

  // holding-empty interrupt and transmitter ready, timed from start bit
  always @(posedge sys_clk) begin
    if (rst) begin
      holding_empty_flag_ff     <= 1'b0;
      holding_empty_flag_cnt_ff <= 6'd0;
      transmitter_ready_out_ff    <= 1'b1;
    end else begin
      if (fifo_pop) begin
        holding_empty_flag_cnt_ff <= {1'b0, `HOLDING_EMPTY_FLAG_AFTER_START};
      end else if (baud_tick && holding_empty_flag_cnt_ff != 6'd0) begin
        holding_empty_flag_cnt_ff <= holding_empty_flag_cnt_ff - 6'd1;
      end
      if (thr_write && thr_ready)
        holding_empty_flag_ff <= 1'b0;
      else if (baud_tick && holding_empty_flag_cnt_ff == 6'd1 && !fifo_out_valid)
        holding_empty_flag_ff <= 1'b1;
      else if (iir_read && interrupt_ident_reg == 4'h2)
        holding_empty_flag_ff <= 1'b0;
      if (thr_write && thr_ready)
        transmitter_ready_out_ff <= 1'b0;
      else if (baud_tick && holding_empty_flag_cnt_ff == 6'd1)
        transmitter_ready_out_ff <= 1'b1;
    end
  end
  assign holding_empty_flag    = holding_empty_flag_src;
  assign transmitter_ready_out = ~transmitter_ready_out_ff;

  // receiver: sampled on receive-clock ticks, 16 per bit
  assign rx_count = rx_wr_ff - rx_rd_ff;
  assign rx_push  = rx_busy_ff && rx_clk_tick && rx_bit_ff == 4'd9 && rx_tick_ff == 5'd1 &&
                    rx_count != RX_DEPTH_W;
  assign rx_pop   = receive_read_strobe && rx_count != 5'd0;

  always @(posedge sys_clk) begin
    if (rx_push)
      rx_mem[rx_wr_ff[3:0]] <= rx_shift_ff;
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      rx_busy_ff  <= 1'b0;
      rx_tick_ff  <= 5'd0;
      rx_bit_ff   <= 4'd0;
      rx_shift_ff <= 8'h00;
      rx_wr_ff    <= 5'd0;
      rx_rd_ff    <= 5'd0;
      receive_buffer <= 8'h00;
    end else begin
      if (rx_clk_tick) begin
        if (!rx_busy_ff) begin
          if (!rx_ff) begin
            rx_busy_ff <= 1'b1;
            rx_tick_ff <= `STOP_MID_TICK;
            rx_bit_ff  <= 4'd0;
          end
        end else if (rx_tick_ff == 5'd1) begin
          rx_tick_ff <= `TICKS_PER_BIT;
          if (rx_bit_ff == 4'd0 && rx_ff)
            rx_busy_ff <= 1'b0;
          else if (rx_bit_ff == 4'd9)
            rx_busy_ff <= 1'b0;
          else begin
            rx_bit_ff <= rx_bit_ff + 4'd1;
            if (rx_bit_ff != 4'd0)
              rx_shift_ff <= {rx_ff, rx_shift_ff[7:1]};
          end
        end else begin
          rx_tick_ff <= rx_tick_ff - 5'd1;
        end
      end
      if (rx_push)
        rx_wr_ff <= rx_wr_ff + 5'd1;
      if (rx_pop) begin
        rx_rd_ff       <= rx_rd_ff + 5'd1;
        receive_buffer <= rx_mem[rx_rd_ff[3:0]];
      end
    end
  end

  // receive interrupt and ready: set beats a simultaneous read-clear
  always @(posedge sys_clk) begin
    if (rst) begin
      rda_ff     <= 1'b0;
      receiver_ready_out_n_ff <= 1'b1;
    end else begin
      if (rx_push)
        rda_ff <= 1'b1;
      else if (receive_read_strobe || lsr_read)
        rda_ff <= 1'b0;
      if (rx_push)
        receiver_ready_out_n_ff <= 1'b0;
      else if (rx_pop && rx_count == 5'd1)
        receiver_ready_out_n_ff <= 1'b1;
    end
  end
  assign receiver_ready_out = receiver_ready_out_n_ff;
  assign interrupt_ident_reg = rda_ff ? 4'h4 : (holding_empty_flag_ff ? 4'h2 : 4'h1);
  assign irq = rda_ff | holding_empty_flag_ff;

  // request-to-send flow: target level changes, then commits on the first baud tick after it is marked pending
  assign nxt_rts_n = !auto_rts_en ? 1'b0 :
                     (rx_count >= rx_threshold) ? 1'b1 :
                     (rx_count == `RX_FULL_LEVEL - 5'd1 && rx_busy_ff && rx_bit_ff != 4'd0) ? 1'b1 :
                     (rx_count == 5'd0) ? 1'b0 : rts_n_ff;

  always @(posedge sys_clk) begin
    if (rst) begin
      rts_n_ff    <= 1'b1;
      rts_pend_ff <= 1'b0;
      rts_cnt_ff  <= 2'd0;
    end else if (nxt_rts_n == rts_n_ff) begin
      rts_pend_ff <= 1'b0;
      rts_cnt_ff  <= 2'd0;
    end else if (!rts_pend_ff) begin
      rts_pend_ff <= 1'b1;
      rts_cnt_ff  <= 2'd1;
    end else if (baud_tick) begin
      if (rts_cnt_ff == 2'd1)
        rts_n_ff <= nxt_rts_n;
      rts_cnt_ff <= rts_cnt_ff - 2'd1;
    end
  end
  assign rts_n_pin = rts_n_ff;
endmodule
